// ===== core/psuind_pkg.sv
// Purpose: shared constants for the power module status indicator logic
// Assumes: 20 MHz sys_clk, AXI4-Lite register access with 32-bit data
// Notes: offsets are byte addresses of aligned 32-bit words
package psuind_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam int ADDR_W = 5;
	localparam logic [2:0] IDX_CTRL = 3'h0; // control, byte 0x00
	localparam logic [2:0] IDX_WARN = 3'h1; // sticky warnings, byte 0x04
	localparam logic [2:0] IDX_FAULT = 3'h2; // sticky faults, byte 0x08
	localparam logic [2:0] IDX_COMM = 3'h3; // sticky comm errors, byte 0x0C
	localparam logic [2:0] IDX_STATE = 3'h4; // live state, byte 0x10
	localparam logic [2:0] IDX_LAST = 3'h4;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ****************************************
	// fields and reset values
	// ****************************************
	localparam int CTRL_CLR_BIT = 0; // write 1: clear all sticky flags
	localparam int CTRL_MAIN_BIT = 1; // main output enable
	localparam int CTRL_SB_BIT = 2; // standby output enable
	localparam logic [7:0] CTRL_RESET = 8'h06;
	localparam int FLAG_W = 8;
	localparam int ST_GOOD_BIT = 5; // state: input acceptable
	localparam int ST_MAIN_BIT = 6; // state: main output running
	localparam int ST_BLINK_BIT = 7; // state: blink phase

	// input classification pins
	localparam int PIN_PRESENT = 0;
	localparam int PIN_OV_LIMIT = 1;
	localparam int PIN_OV_WARN = 2;
	localparam int PIN_UV_WARN = 3;
	localparam int PIN_UV_LIMIT = 4;
	localparam int NUM_PINS = 5;

	// ****************************************
	// timing
	// ****************************************
	localparam int unsigned CLK_KHZ = 20000;
	localparam int unsigned PREWARN_US = 5000; // least input-ok lead before main loss
	localparam int unsigned PREWARN_CYC = (PREWARN_US * CLK_KHZ + 999) / 1000;
	localparam int unsigned BLINK_HALF_MS = 500; // half period of blinking
	localparam int unsigned BLINK_CYC = BLINK_HALF_MS * CLK_KHZ;

	// output indicator pattern
	typedef enum logic [2:0] {
		OM_OFF = 3'b000,
		OM_GREEN = 3'b001,
		OM_GREEN_BLINK = 3'b010,
		OM_AMBER_BLINK = 3'b011,
		OM_AMBER = 3'b100
	} psuind_mode_e;
endpackage

// ===== core/psuind_sync.sv
// Purpose: three-stage synchroniser with agreement filter
// Assumes: inputs are asynchronous to sys_clk
// Notes: output changes only once stages two and three agree
`timescale 1ns/1ps
module psuind_sync #(
	parameter int WIDTH = 1
) (
	input wire logic sys_clk, // system clock
	input wire logic reset, // async reset, active high
	input wire logic [WIDTH-1:0] din, // asynchronous inputs
	output logic [WIDTH-1:0] dout // filtered synchronous outputs
);
	logic [WIDTH-1:0] s1;
	logic [WIDTH-1:0] s2;
	logic [WIDTH-1:0] s3;

	// shift chain; s1 feeds only s2
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// accept a bit only when the last two stages agree
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			dout <= '0;
		end else begin
			dout <= (s2 & s3) | (dout & (s2 | s3));
		end
	end
endmodule

// ===== core/psuind_top.sv
// Purpose: front panel indicators, input-ok and alert for a power module
// Assumes: flag inputs come from logic on sys_clk; voltage class pins are async
// Notes: open-drain pins are driven low while their enable is high
`timescale 1ns/1ps
module psuind_top
	import psuind_pkg::*;
#(
	parameter int unsigned HOLD_CYC = PREWARN_CYC, // main hold after input-ok drop
	parameter int unsigned BLINK_HALF = BLINK_CYC // cycles per blink half period
) (
	input wire logic sys_clk, // system clock, 20 MHz
	input wire logic reset, // async reset, active high
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write byte strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [NUM_PINS-1:0] vin_class, // input voltage class pins, async
	input wire logic [FLAG_W-1:0] warn_flags, // warning events
	input wire logic [FLAG_W-1:0] fault_flags, // fault events
	input wire logic [FLAG_W-1:0] comm_err_flags, // communication error events
	output logic in_led_green, // input indicator green
	output logic out_led_green, // output indicator green
	output logic out_led_amber, // output indicator amber
	output logic input_ok_o, // input-ok pin drive level
	output logic input_ok_oe, // input-ok pulled low when high
	output logic alert_n_o, // alert pin drive level
	output logic alert_oe, // alert pulled low when high
	output logic main_run // main 12 V output enable
);
	localparam int LW = $clog2(HOLD_CYC + 1);
	localparam int BW = $clog2(BLINK_HALF + 1);

	// ****************************************
	// declarations
	// ****************************************
	logic [NUM_PINS-1:0] vin_s;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0] w_data;
	logic [3:0] w_strb;
	logic wr_go;
	logic [2:0] aw_idx;
	logic [2:0] ar_idx;
	logic main_en;
	logic sb_en;
	logic clr_pulse;
	logic [FLAG_W-1:0] warn_sticky;
	logic [FLAG_W-1:0] fault_sticky;
	logic [FLAG_W-1:0] comm_sticky;
	logic [LW-1:0] loss_cnt;
	logic [BW-1:0] blink_cnt;
	logic blink_phase;
	logic in_good;
	logic in_norm;
	logic in_band;
	logic warn_any;
	logic fault_any;
	psuind_mode_e next_mode;
	psuind_mode_e out_mode;
	logic [LW:0] oe_age;

	// ****************************************
	// input synchronisation and class
	// ****************************************
	psuind_sync #(
		.WIDTH(NUM_PINS)
	) u_sync (
		.sys_clk(sys_clk),
		.reset(reset),
		.din(vin_class),
		.dout(vin_s)
	);

	// classification of the filtered pins
	assign in_good = vin_s[PIN_PRESENT] & ~vin_s[PIN_OV_LIMIT] & ~vin_s[PIN_UV_LIMIT];
	assign in_band = vin_s[PIN_OV_WARN] | vin_s[PIN_UV_WARN];
	assign in_norm = in_good & ~in_band;
	assign warn_any = |warn_sticky;
	assign fault_any = |fault_sticky;

	// ****************************************
	// register bus
	// ****************************************
	assign aw_idx = aw_addr[4:2];
	assign ar_idx = s_axi_araddr[4:2];
	assign wr_go = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;

	// write address channel, one write at a time
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_axi_awready <= 1'b1;
			aw_addr <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_addr <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
		end
	end

	// write data channel
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_axi_wready <= 1'b1;
			w_data <= '0;
			w_strb <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_data <= s_axi_wdata;
			w_strb <= s_axi_wstrb;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
		end
	end

	// write response after both halves arrived
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (wr_go) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (aw_idx <= IDX_LAST) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// control register and clear-faults pulse
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			main_en <= CTRL_RESET[CTRL_MAIN_BIT];
			sb_en <= CTRL_RESET[CTRL_SB_BIT];
			clr_pulse <= 1'b0;
		end else if (wr_go && aw_idx == IDX_CTRL && w_strb[0]) begin
			main_en <= w_data[CTRL_MAIN_BIT];
			sb_en <= w_data[CTRL_SB_BIT];
			clr_pulse <= w_data[CTRL_CLR_BIT];
		end else begin
			clr_pulse <= 1'b0;
		end
	end

	// read channel, data one cycle after address
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (ar_idx)
				IDX_CTRL: s_axi_rdata <= {29'h0, sb_en, main_en, 1'b0};
				IDX_WARN: s_axi_rdata <= {24'h0, warn_sticky};
				IDX_FAULT: s_axi_rdata <= {24'h0, fault_sticky};
				IDX_COMM: s_axi_rdata <= {24'h0, comm_sticky};
				IDX_STATE: s_axi_rdata <= {24'h0, blink_phase, main_run, in_good, vin_s};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ****************************************
	// sticky status flags
	// ****************************************
	// new events win over a clear in the same cycle
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			warn_sticky <= '0;
			fault_sticky <= '0;
			comm_sticky <= '0;
		end else begin
			warn_sticky <= (warn_sticky & ~{FLAG_W{clr_pulse}}) | warn_flags;
			fault_sticky <= (fault_sticky & ~{FLAG_W{clr_pulse}}) | fault_flags;
			comm_sticky <= (comm_sticky & ~{FLAG_W{clr_pulse}}) | comm_err_flags;
		end
	end

	// ****************************************
	// blink timebase
	// ****************************************
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			blink_cnt <= '0;
			blink_phase <= 1'b0;
		end else if (blink_cnt == BW'(BLINK_HALF - 1)) begin
			blink_cnt <= '0;
			blink_phase <= ~blink_phase;
		end else begin
			blink_cnt <= blink_cnt + 1'b1;
		end
	end

	// ****************************************
	// indicators
	// ****************************************
	// input indicator from voltage class
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			in_led_green <= 1'b0;
		end else if (in_norm) begin
			in_led_green <= 1'b1;
		end else if (in_good && in_band) begin
			in_led_green <= blink_phase;
		end else begin
			in_led_green <= 1'b0;
		end
	end

	// output pattern selection, fault first
	always_comb begin
		if (fault_any) begin
			next_mode = OM_AMBER;
		end else if (warn_any) begin
			next_mode = OM_AMBER_BLINK;
		end else if (main_run && sb_en) begin
			next_mode = OM_GREEN;
		end else if (sb_en) begin
			next_mode = OM_GREEN_BLINK;
		end else begin
			next_mode = OM_OFF;
		end
	end

	// output indicator drive
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			out_mode <= OM_OFF;
			out_led_green <= 1'b0;
			out_led_amber <= 1'b0;
		end else begin
			out_mode <= next_mode;
			unique case (next_mode)
				OM_OFF: begin
					out_led_green <= 1'b0;
					out_led_amber <= 1'b0;
				end
				OM_GREEN: begin
					out_led_green <= 1'b1;
					out_led_amber <= 1'b0;
				end
				OM_GREEN_BLINK: begin
					out_led_green <= blink_phase;
					out_led_amber <= 1'b0;
				end
				OM_AMBER_BLINK: begin
					out_led_green <= 1'b0;
					out_led_amber <= blink_phase;
				end
				OM_AMBER: begin
					out_led_green <= 1'b0;
					out_led_amber <= 1'b1;
				end
			endcase
		end
	end

	// alert pin with the amber modes only
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			alert_oe <= 1'b0;
			alert_n_o <= 1'b0;
		end else begin
			alert_oe <= fault_any | warn_any;
			alert_n_o <= 1'b0;
		end
	end

	// ****************************************
	// input-ok and main hold-up
	// ****************************************
	// filtered class drives the pin, no raw pin path
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			input_ok_oe <= 1'b1;
			input_ok_o <= 1'b0;
		end else begin
			input_ok_oe <= ~in_good;
			input_ok_o <= 1'b0;
		end
	end

	// main output kept alive for the pre-warning time
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			loss_cnt <= '0;
			main_run <= 1'b0;
		end else if (in_good) begin
			loss_cnt <= '0;
			main_run <= main_en;
		end else if (loss_cnt == LW'(HOLD_CYC)) begin
			main_run <= 1'b0;
		end else begin
			loss_cnt <= loss_cnt + 1'b1;
			main_run <= main_run & main_en;
		end
	end

	// ****************************************
	// assertions
	// ****************************************
	// cycles spent with input-ok pulled low
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			oe_age <= '0;
		end else if (!input_ok_oe) begin
			oe_age <= '0;
		end else if (oe_age != {(LW + 1){1'b1}}) begin
			oe_age <= oe_age + 1'b1;
		end
	end

	a_in_steady: assert property (@(posedge sys_clk) disable iff (reset) in_norm |=> in_led_green)
		else $error("input indicator not steady green in normal range");
	a_in_blink: assert property (@(posedge sys_clk) disable iff (reset)
		(in_good && in_band) |=> (in_led_green == $past(blink_phase)))
		else $error("input indicator not blinking in warning band");
	a_in_off: assert property (@(posedge sys_clk) disable iff (reset) !in_good |=> !in_led_green)
		else $error("input indicator lit with input out of limits");
	a_out_green: assert property (@(posedge sys_clk) disable iff (reset)
		(!fault_any && !warn_any && main_run && sb_en) |=> (out_led_green && !out_led_amber))
		else $error("output indicator not steady green");
	a_out_standby: assert property (@(posedge sys_clk) disable iff (reset)
		(!fault_any && !warn_any && !main_run && sb_en) |=> (out_led_green == $past(blink_phase)))
		else $error("output indicator not blinking green in standby");
	a_warn_blink: assert property (@(posedge sys_clk) disable iff (reset)
		(warn_any && !fault_any) |=> (out_led_amber == $past(blink_phase) && !out_led_green))
		else $error("warning not shown as blinking amber");
	a_fault_amber: assert property (@(posedge sys_clk) disable iff (reset)
		fault_any |=> (out_led_amber && !out_led_green && out_mode == OM_AMBER))
		else $error("fault not shown as steady amber");
	a_sticky_hold: assert property (@(posedge sys_clk) disable iff (reset)
		!clr_pulse |=> ((fault_sticky & $past(fault_sticky)) == $past(fault_sticky)
		&& (warn_sticky & $past(warn_sticky)) == $past(warn_sticky)))
		else $error("sticky flag dropped without clear");
	a_sticky_clear: assert property (@(posedge sys_clk) disable iff (reset)
		(clr_pulse && warn_flags == '0) |=> (warn_sticky == '0))
		else $error("clear did not empty warning flags");
	a_ok_follows: assert property (@(posedge sys_clk) disable iff (reset)
		##1 (input_ok_oe == !$past(in_good)))
		else $error("input-ok does not follow filtered input");
	a_prewarn: assert property (@(posedge sys_clk) disable iff (reset)
		($fell(main_run) && input_ok_oe) |-> (oe_age >= (LW + 1)'(HOLD_CYC)))
		else $error("main lost before pre-warning time");
	a_alert_amber: assert property (@(posedge sys_clk) disable iff (reset)
		##1 (alert_oe == (out_mode == OM_AMBER || out_mode == OM_AMBER_BLINK)))
		else $error("alert and amber indication disagree");

	c_fault_shown: cover property (@(posedge sys_clk) disable iff (reset) $rose(out_led_amber) && fault_any);
	c_standby: cover property (@(posedge sys_clk) disable iff (reset) out_mode == OM_GREEN_BLINK);
	c_prewarn: cover property (@(posedge sys_clk) disable iff (reset) $fell(main_run) && input_ok_oe);
	c_cleared: cover property (@(posedge sys_clk) disable iff (reset) $fell(alert_oe));
endmodule

// ===== testbench/psuind_host.sv
// Purpose: host side of the open-drain status pins
// Assumes: pins have pull-ups on the host side
// Notes: a released pin reads high, never the last driven level
`timescale 1ns/1ps
module psuind_host (
	input wire logic input_ok_o, // input-ok drive level
	input wire logic input_ok_oe, // input-ok pulled low when high
	input wire logic alert_n_o, // alert drive level
	input wire logic alert_oe, // alert pulled low when high
	output logic input_ok_pin, // input-ok as the host sees it
	output logic alert_n_pin // alert as the host sees it
);
	// ****************************************
	// pin resolution
	// ****************************************
	// pull-up wins whenever the module lets go
	assign input_ok_pin = input_ok_oe ? input_ok_o : 1'b1;
	assign alert_n_pin = alert_oe ? alert_n_o : 1'b1;
endmodule

// ===== testbench/tb.sv
// Purpose: self-checking bench for the status indicator block
// Assumes: short hold and blink counts set by parameter
// Notes: registers reached over AXI4-Lite, flags pulsed one cycle
`timescale 1ns/1ps
module tb;
	import psuind_pkg::*;
	localparam int HOLD = 20;
	localparam int BH = 4;
	localparam int NS = 24;
	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic [ADDR_W-1:0] awaddr = '0;
	logic [ADDR_W-1:0] araddr = '0;
	logic awvalid = 1'b0;
	logic wvalid = 1'b0;
	logic bready = 1'b0;
	logic arvalid = 1'b0;
	logic rready = 1'b0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = '0;
	logic awready, wready, bvalid, arready, rvalid;
	logic [31:0] rdata;
	logic [1:0] bresp, rresp;
	logic [NUM_PINS-1:0] vin = '0;
	logic [FLAG_W-1:0] warn = '0;
	logic [FLAG_W-1:0] fault = '0;
	logic [FLAG_W-1:0] comm = '0;
	logic in_g, out_g, out_a, ok_o, ok_oe, al_o, al_oe, main_run, ok_pin, al_n_pin;
	logic [4:0] tab [6] = '{5'h01, 5'h05, 5'h09, 5'h03, 5'h11, 5'h00};
	logic [4:0] v;
	logic [7:0] x;
	int miscompares = 0;
	int n_checks = 0;
	int cyc = 0;
	int c [4];
	int k, g;
	integer seed = 32'h3FA4;

	// ****************************************
	// clock, design and host pins
	// ****************************************
	always #25 sys_clk = ~sys_clk;

	psuind_top #(.HOLD_CYC(HOLD), .BLINK_HALF(BH)) i_dut (.sys_clk(sys_clk), .reset(reset),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.vin_class(vin), .warn_flags(warn), .fault_flags(fault), .comm_err_flags(comm),
		.in_led_green(in_g), .out_led_green(out_g), .out_led_amber(out_a),
		.input_ok_o(ok_o), .input_ok_oe(ok_oe), .alert_n_o(al_o), .alert_oe(al_oe),
		.main_run(main_run));

	psuind_host i_host (.input_ok_o(ok_o), .input_ok_oe(ok_oe), .alert_n_o(al_o),
		.alert_oe(al_oe), .input_ok_pin(ok_pin), .alert_n_pin(al_n_pin));

	// ****************************************
	// checking helpers
	// ****************************************
	task give_verdict;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask

	// 0 never lit, 1 always lit, 2 blinking
	function logic [31:0] pat(input int n);
		return (n == 0) ? 0 : ((n == NS) ? 1 : 2);
	endfunction

	// input indicator pattern from the voltage class
	function logic [31:0] exp_in(input logic [4:0] cl);
		if (!cl[PIN_PRESENT] || cl[PIN_OV_LIMIT] || cl[PIN_UV_LIMIT])
			return 0;
		return (cl[PIN_OV_WARN] || cl[PIN_UV_WARN]) ? 2 : 1;
	endfunction

	// count lit cycles of every indicator
	task obs;
		c = '{default: 0};
		repeat (NS) begin
			@(posedge sys_clk);
			#1;
			c[0] += int'(in_g);
			c[1] += int'(out_g);
			c[2] += int'(out_a);
			c[3] += int'(!al_n_pin);
		end
	endtask

	task out_chk(input logic [31:0] eg, input logic [31:0] ea, input logic [31:0] el);
		// input filter, main restart and indicator register all settle first
		repeat (8) @(posedge sys_clk);
		obs;
		chk("out_green", eg, pat(c[1]));
		chk("out_amber", ea, pat(c[2]));
		chk("alert", el, pat(c[3]));
	endtask

	task pulse(input logic [7:0] w, input logic [7:0] f, input logic [7:0] cm);
		@(posedge sys_clk);
		warn <= w;
		fault <= f;
		comm <= cm;
		@(posedge sys_clk);
		warn <= '0;
		fault <= '0;
		comm <= '0;
	endtask

	// ****************************************
	// register bus master
	// ****************************************
	task axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge sys_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= 4'hF;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
		end while (!(bvalid && bready));
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	task axi_rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arvalid && arready)
				arvalid <= 1'b0;
		end while (!(rvalid && rready));
		rready <= 1'b0;
		chk("rdata", ed, rdata);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
	endtask

	// ****************************************
	// hang guard
	// ****************************************
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			$display("[ERR] timeout expected done seen hang");
			give_verdict;
		end
	end

	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		axi_rd(5'h00, 32'h6, RESP_OKAY);
		axi_rd(5'h14, 32'h0, RESP_SLVERR);
		axi_wr(5'h18, 32'h1, RESP_SLVERR);
		$display("test registers done");
		// fixed classes first, then random ones
		for (int i = 0; i < 10; i++) begin
			v = (i < 6) ? tab[i] : 5'($random(seed));
			@(posedge sys_clk);
			vin <= v;
			repeat (8) @(posedge sys_clk);
			obs;
			chk("in_led", exp_in(v), pat(c[0]));
			chk("input_ok", {31'h0, exp_in(v) != 0}, {31'h0, ok_pin});
		end
		$display("test input indicator done");
		// input loss: pre-warning lead and no false good level
		@(posedge sys_clk);
		vin <= 5'h01;
		repeat (12) @(posedge sys_clk);
		#1;
		chk("main_run", 32'h1, {31'h0, main_run});
		@(posedge sys_clk);
		vin <= 5'h00;
		k = 0;
		while (ok_pin !== 1'b0 && k < 20) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		k = 0;
		g = 0;
		while (main_run !== 1'b0 && k < 200) begin
			@(posedge sys_clk);
			#1;
			k++;
			if (ok_pin !== 1'b0)
				g++;
		end
		chk("hold_lead", 32'h1, {31'h0, k >= HOLD});
		chk("ok_glitch", 32'h0, g);
		$display("test input loss done");
		// output indicator patterns and sticky flags
		@(posedge sys_clk);
		vin <= 5'h01;
		out_chk(1, 0, 0);
		axi_wr(5'h00, 32'h0, RESP_OKAY);
		out_chk(0, 0, 0);
		axi_wr(5'h00, 32'h4, RESP_OKAY);
		out_chk(2, 0, 0);
		x = 8'($random(seed)) | 8'h01;
		pulse(8'h00, 8'h00, x);
		out_chk(2, 0, 0);
		axi_rd(5'h0C, {24'h0, x}, RESP_OKAY);
		x = 8'($random(seed)) | 8'h01;
		pulse(x, 8'h00, 8'h00);
		out_chk(0, 2, 1);
		axi_rd(5'h04, {24'h0, x}, RESP_OKAY);
		x = 8'($random(seed)) | 8'h01;
		pulse(8'h00, x, 8'h00);
		out_chk(0, 1, 1);
		axi_wr(5'h00, 32'h7, RESP_OKAY);
		out_chk(1, 0, 0);
		axi_rd(5'h08, 32'h0, RESP_OKAY);
		$display("test output indicator done");
		give_verdict;
	end
endmodule
